//--- rtl/efb_defs.vh
// Constants for the Ethernet frame buffering block
`ifndef EFB_DEFS_VH
`define EFB_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EFB_REG_CTRL      8'h00
`define EFB_REG_IRQ_STAT  8'h04
`define EFB_REG_IRQ_MASK  8'h08
`define EFB_REG_UNI_LO    8'h0C
`define EFB_REG_UNI_HI    8'h10
`define EFB_REG_MC_BASE   8'h14
`define EFB_REG_TXCNT_LO  8'h34
`define EFB_REG_TXCNT_HI  8'h38
`define EFB_REG_RXCNT_LO  8'h3C
`define EFB_REG_RXCNT_HI  8'h40
`define EFB_REG_DROP_LO   8'h44
`define EFB_REG_DROP_HI   8'h48
`define EFB_REG_LEVEL     8'h4C

// ----------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------
`define EFB_CTRL_PROMISC  0
`define EFB_CTRL_BCAST    1
`define EFB_CTRL_VSTRIP   2
`define EFB_CTRL_ALLMC    3
`define EFB_CTRL_W        4
`define EFB_CTRL_RESET    4'h2

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define EFB_IRQ_TX_DONE   0
`define EFB_IRQ_RX_DONE   1
`define EFB_IRQ_DROP_FULL 2
`define EFB_IRQ_DROP_FMT  3
`define EFB_IRQ_DROP_ADDR 4
`define EFB_IRQ_W         5

// ----------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------
`define EFB_CTL_WORDS     3'h6
`define EFB_MIN_WORDS     5'h10
`define EFB_MC_COUNT      4
`define EFB_VLAN_TPID     16'h0081
`define EFB_DEPTH_DEFAULT 4096
`define EFB_CSUM_W        16

`endif

//--- rtl/efb_frame_mem.v
// Frame memory with commit and rollback of whole frames
`timescale 1ns/100ps
module efb_frame_mem #(
  parameter WIDTH = 53,
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Write side
  input  wire             wr_valid,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             wr_commit,
  input  wire             wr_abort,
  output wire             full,
  // Read side
  output reg              rd_valid,
  output reg  [WIDTH-1:0] rd_data,
  input  wire             rd_ready,
  // Fill level in words
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      commit_ptr;
  reg [AW:0]      rd_ptr;

  wire [AW:0] one   = {{AW{1'b0}}, 1'b1};
  wire        wr_go = wr_valid & ~full & ~wr_abort;
  // Only committed words are visible to the reader
  wire        avail = (commit_ptr != rd_ptr);
  wire        load  = avail & (~rd_valid | rd_ready);

  assign level = wr_ptr - rd_ptr;
  // Depth is a power of two, so full is the top bit of the level
  assign full  = level[AW];

  // ----------------------------------------------------------------
  // Write pointers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (wr_go)
      mem[wr_ptr[AW-1:0]] <= wr_data;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr     <= {(AW+1){1'b0}};
      commit_ptr <= {(AW+1){1'b0}};
    end else if (wr_abort) begin
      wr_ptr <= commit_ptr;
    end else begin
      if (wr_go)
        wr_ptr <= wr_ptr + one;
      if (wr_commit)
        commit_ptr <= wr_go ? wr_ptr + one : wr_ptr;
    end
  end

  // ----------------------------------------------------------------
  // Read side, registered output stage
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr   <= {(AW+1){1'b0}};
      rd_valid <= 1'b0;
      rd_data  <= {WIDTH{1'b0}};
    end else if (load) begin
      rd_data  <= mem[rd_ptr[AW-1:0]];
      rd_ptr   <= rd_ptr + one;
      rd_valid <= 1'b1;
    end else if (rd_ready) begin
      rd_valid <= 1'b0;
    end
  end

endmodule // efb_frame_mem

//--- rtl/efb_top.v
// Ethernet frame buffering: transmit and receive frame memories
`timescale 1ns/100ps
`include "efb_defs.vh"
module efb_top #(
  parameter tx_buffer_depth_param     = `EFB_DEPTH_DEFAULT,
  parameter rx_buffer_depth_param     = `EFB_DEPTH_DEFAULT,
  parameter tx_checksum_option        = 0,
  parameter rx_checksum_option        = 0,
  parameter vlan_option               = 0,
  parameter extended_multicast_option = 0,
  parameter statistics_option         = 0,
  parameter av_bridging_option        = 0,
  parameter line_rate_mbps            = 1000
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  output wire        irq,
  // Transmit control stream from system
  input  wire        txc_tvalid,
  input  wire [31:0] txc_tdata,
  input  wire        txc_tlast,
  output wire        txc_tready,
  // Transmit data stream from system
  input  wire        txd_tvalid,
  input  wire [31:0] txd_tdata,
  input  wire [3:0]  txd_tkeep,
  input  wire        txd_tlast,
  output wire        txd_tready,
  // Transmit stream to MAC
  output wire        mtx_tvalid,
  output wire [31:0] mtx_tdata,
  output wire [3:0]  mtx_tkeep,
  output wire        mtx_tlast,
  output wire [15:0] mtx_tcsum,
  input  wire        mtx_tready,
  // Receive stream from MAC, no back-pressure
  input  wire        mrx_tvalid,
  input  wire [31:0] mrx_tdata,
  input  wire [3:0]  mrx_tkeep,
  input  wire        mrx_tlast,
  input  wire        mrx_bad,
  // Receive stream to system
  output wire        rxd_tvalid,
  output wire [31:0] rxd_tdata,
  output wire [3:0]  rxd_tkeep,
  output wire        rxd_tlast,
  output wire [15:0] rxd_tcsum,
  input  wire        rxd_tready
);

  function integer clog2;
    input integer v;
    integer i;
    begin
      clog2 = 0;
      for (i = v - 1; i > 0; i = i >> 1)
        clog2 = clog2 + 1;
    end
  endfunction

  // Ones-complement 16-bit add, shared by both checksum paths
  function [15:0] csum_add;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      csum_add = s[15:0] + {15'h0000, s[16]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Build-time option checks
  // ----------------------------------------------------------------
  // Unsupported mixes fall back to a legal build; no error is raised,
  // so the option set must be checked by whoever builds the block
  function legal_depth;
    input integer d;
    begin
      legal_depth = (d == 4096) || (d == 8192) || (d == 16384) ||
                    (d == 32768);
    end
  endfunction

  localparam TX_DEPTH = legal_depth(tx_buffer_depth_param) ?
                        tx_buffer_depth_param : `EFB_DEPTH_DEFAULT;
  localparam RX_DEPTH = legal_depth(rx_buffer_depth_param) ?
                        rx_buffer_depth_param : `EFB_DEPTH_DEFAULT;
  localparam VLAN_ON  = (vlan_option != 0) && (tx_checksum_option == 0) &&
                        (rx_checksum_option == 0);
  localparam AVB_ON   = (av_bridging_option != 0) &&
                        (line_rate_mbps == 100 || line_rate_mbps == 1000);
  localparam TX_WORDS = TX_DEPTH / 4;
  localparam RX_WORDS = RX_DEPTH / 4;
  localparam TX_AW    = clog2(TX_WORDS);
  localparam RX_AW    = clog2(RX_WORDS);
  localparam MW       = 32 + 4 + 1 + `EFB_CSUM_W;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [`EFB_CTRL_W-1:0] ctrl;
  reg  [`EFB_IRQ_W-1:0]  irq_stat;
  reg  [`EFB_IRQ_W-1:0]  irq_mask;
  reg  [47:0]            uni_addr;
  reg  [47:0]            mc_addr [0:`EFB_MC_COUNT-1];
  wire [`EFB_IRQ_W-1:0]  irq_evt;
  wire [63:0]            stat_q [0:2];
  wire [2:0]             stat_evt;
  wire                   tx_full_w;
  wire                   rx_full_w;

  wire acc   = psel & penable;
  wire wr_en = acc & pwrite;
  integer k;
  integer j;

  assign pready = 1'b1;
  assign irq    = |(irq_stat & irq_mask);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl     <= `EFB_CTRL_RESET;
      irq_stat <= {`EFB_IRQ_W{1'b0}};
      irq_mask <= {`EFB_IRQ_W{1'b0}};
      uni_addr <= 48'h000000000000;
      for (k = 0; k < `EFB_MC_COUNT; k = k + 1)
        mc_addr[k] <= 48'h000000000000;
    end else begin
      // Set wins over a write-one clear in the same cycle
      if (wr_en && paddr == `EFB_REG_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[`EFB_IRQ_W-1:0]) | irq_evt;
      else
        irq_stat <= irq_stat | irq_evt;
      if (wr_en) begin
        case (paddr)
          `EFB_REG_CTRL:     ctrl           <= pwdata[`EFB_CTRL_W-1:0];
          `EFB_REG_IRQ_MASK: irq_mask       <= pwdata[`EFB_IRQ_W-1:0];
          `EFB_REG_UNI_LO:   uni_addr[31:0] <= pwdata;
          `EFB_REG_UNI_HI:   uni_addr[47:32] <= pwdata[15:0];
          default: begin
          end
        endcase
        for (k = 0; k < `EFB_MC_COUNT; k = k + 1) begin
          if (paddr == `EFB_REG_MC_BASE + k * 8)
            mc_addr[k][31:0] <= pwdata;
          if (paddr == `EFB_REG_MC_BASE + k * 8 + 4)
            mc_addr[k][47:32] <= pwdata[15:0];
        end
      end
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `EFB_REG_CTRL:     rd_mux = {28'h0000000, ctrl};
      `EFB_REG_IRQ_STAT: rd_mux = {27'h0000000, irq_stat};
      `EFB_REG_IRQ_MASK: rd_mux = {27'h0000000, irq_mask};
      `EFB_REG_UNI_LO:   rd_mux = uni_addr[31:0];
      `EFB_REG_UNI_HI:   rd_mux = {16'h0000, uni_addr[47:32]};
      `EFB_REG_TXCNT_LO: rd_mux = stat_q[0][31:0];
      `EFB_REG_TXCNT_HI: rd_mux = stat_q[0][63:32];
      `EFB_REG_RXCNT_LO: rd_mux = stat_q[1][31:0];
      `EFB_REG_RXCNT_HI: rd_mux = stat_q[1][63:32];
      `EFB_REG_DROP_LO:  rd_mux = stat_q[2][31:0];
      `EFB_REG_DROP_HI:  rd_mux = stat_q[2][63:32];
      `EFB_REG_LEVEL:    rd_mux = {16'h0000, 10'h000, tx_full_w, rx_full_w,
                                   4'h0};
      default:           rd_hit = 1'b0;
    endcase
    for (j = 0; j < `EFB_MC_COUNT; j = j + 1) begin
      if (paddr == `EFB_REG_MC_BASE + j * 8) begin
        rd_mux = mc_addr[j][31:0];
        rd_hit = 1'b1;
      end
      if (paddr == `EFB_REG_MC_BASE + j * 8 + 4) begin
        rd_mux = {16'h0000, mc_addr[j][47:32]};
        rd_hit = 1'b1;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~rd_hit;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  reg         ctl_done;
  reg  [15:0] tx_sum;
  wire [15:0] tx_sum_next = csum_add(csum_add(tx_sum, txd_tdata[31:16]),
                                     txd_tdata[15:0]);
  wire        txd_beat = txd_tvalid & txd_tready;
  wire [15:0] tx_csum_st = (tx_checksum_option != 0 && txd_tlast) ?
                           tx_sum_next : 16'h0000;

  // control ready until its last word is taken, then held off until frame data ends
  assign txc_tready = ~ctl_done;
  assign txd_tready = ctl_done & ~tx_full_w;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_done <= 1'b0;
      tx_sum   <= 16'h0000;
    end else begin
      if (txc_tvalid & txc_tready & txc_tlast)
        ctl_done <= 1'b1;
      if (txd_beat) begin
        tx_sum <= txd_tlast ? 16'h0000 : tx_sum_next;
        if (txd_tlast)
          ctl_done <= 1'b0;
      end
    end
  end

  efb_frame_mem #(
    .WIDTH (MW),
    .DEPTH (TX_WORDS),
    .AW    (TX_AW)
  ) u_tx_mem (
    .clk       (clk),
    .rst       (rst),
    .wr_valid  (txd_beat),
    .wr_data   ({tx_csum_st, txd_tlast, txd_tkeep, txd_tdata}),
    .wr_commit (txd_beat & txd_tlast),
    .wr_abort  (1'b0),
    .full      (tx_full_w),
    .rd_valid  (mtx_tvalid),
    .rd_data   ({mtx_tcsum, mtx_tlast, mtx_tkeep, mtx_tdata}),
    .rd_ready  (mtx_tready),
    .level     ()
  );

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  reg  [4:0]  widx;
  reg  [31:0] word0;
  reg         drop;
  reg         drop_full;
  reg         drop_addr;
  reg  [15:0] rx_sum;
  wire [47:0] dst = {mrx_tdata[15:0], word0};
  wire [3:0]  mc_hit;

  genvar g;
  generate
    for (g = 0; g < `EFB_MC_COUNT; g = g + 1) begin : g_mc
      assign mc_hit[g] = (dst == mc_addr[g]);
    end
  endgenerate

  wire is_mc   = word0[0];
  wire mc_ok   = is_mc & ((|mc_hit) | (extended_multicast_option != 0 &&
                                       ctrl[`EFB_CTRL_ALLMC]));
  wire addr_ok = ctrl[`EFB_CTRL_PROMISC] | (dst == uni_addr) |
                 ((&dst) & ctrl[`EFB_CTRL_BCAST]) | mc_ok;
  wire addr_fail = (widx == 5'h01) & ~addr_ok;
  wire strip = (VLAN_ON != 0) & ctrl[`EFB_CTRL_VSTRIP] &
               (widx == 5'h03) & (mrx_tdata[15:0] == `EFB_VLAN_TPID);
  wire fmt_bad   = mrx_bad | (widx < `EFB_MIN_WORDS - 5'h01);
  wire drop_now  = drop | addr_fail | rx_full_w;
  wire end_beat  = mrx_tvalid & mrx_tlast;
  wire rx_write  = mrx_tvalid & ~drop_now & ~strip;
  wire rx_commit = end_beat & ~drop_now & ~fmt_bad;
  wire rx_abort  = end_beat & ~rx_commit;
  wire [15:0] rx_sum_next = csum_add(csum_add(rx_sum, mrx_tdata[31:16]),
                                     mrx_tdata[15:0]);
  wire [15:0] rx_csum_st = (rx_checksum_option != 0 && mrx_tlast) ?
                           rx_sum_next : 16'h0000;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      widx      <= 5'h00;
      word0     <= 32'h00000000;
      drop      <= 1'b0;
      drop_full <= 1'b0;
      drop_addr <= 1'b0;
      rx_sum    <= 16'h0000;
    end else if (mrx_tvalid) begin
      if (mrx_tlast) begin
        widx      <= 5'h00;
        drop      <= 1'b0;
        drop_full <= 1'b0;
        drop_addr <= 1'b0;
        rx_sum    <= 16'h0000;
      end else begin
        if (widx != 5'h1F)
          widx <= widx + 5'h01;
        if (widx == 5'h00)
          word0 <= mrx_tdata;
        // once full, rest of frame dropped
        if (rx_full_w & ~drop)
          drop_full <= 1'b1;
        if (addr_fail & ~drop)
          drop_addr <= 1'b1;
        drop <= drop_now;
        if (rx_write)
          rx_sum <= rx_sum_next;
      end
    end
  end

  efb_frame_mem #(
    .WIDTH (MW),
    .DEPTH (RX_WORDS),
    .AW    (RX_AW)
  ) u_rx_mem (
    .clk       (clk),
    .rst       (rst),
    .wr_valid  (rx_write),
    .wr_data   ({rx_csum_st, mrx_tlast, mrx_tkeep, mrx_tdata}),
    .wr_commit (rx_commit),
    .wr_abort  (rx_abort),
    .full      (rx_full_w),
    .rd_valid  (rxd_tvalid),
    .rd_data   ({rxd_tcsum, rxd_tlast, rxd_tkeep, rxd_tdata}),
    .rd_ready  (rxd_tready),
    .level     ()
  );

  // ----------------------------------------------------------------
  // Events and statistics
  // ----------------------------------------------------------------
  wire why_full = drop_full | (rx_full_w & ~drop);
  wire why_addr = ~why_full & (drop_addr | addr_fail);
  assign irq_evt[`EFB_IRQ_TX_DONE]   = mtx_tvalid & mtx_tready & mtx_tlast;
  assign irq_evt[`EFB_IRQ_RX_DONE]   = rx_commit;
  assign irq_evt[`EFB_IRQ_DROP_FULL] = rx_abort & why_full;
  assign irq_evt[`EFB_IRQ_DROP_ADDR] = rx_abort & why_addr;
  assign irq_evt[`EFB_IRQ_DROP_FMT]  = rx_abort & ~why_full & ~why_addr;
  assign stat_evt = {rx_abort, rx_commit, irq_evt[`EFB_IRQ_TX_DONE]};

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_stat
      if (statistics_option != 0) begin : g_on
        reg [63:0] cnt;
        always @(posedge clk or posedge rst) begin
          if (rst)
            cnt <= 64'h0000000000000000;
          else if (stat_evt[g])
            cnt <= cnt + 64'h0000000000000001;
        end
        assign stat_q[g] = cnt;
      end else begin : g_off
        assign stat_q[g] = 64'h0000000000000000;
      end
    end
  endgenerate

endmodule // efb_top

//--- test/efb_top_chk.sv
// Port-level assertions for the frame buffering block
`timescale 1ns/100ps
module efb_top_chk (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Register bus
  input wire        psel,
  input wire        penable,
  input wire [7:0]  paddr,
  input wire        pready,
  input wire        pslverr,
  // Transmit streams
  input wire        txc_tvalid,
  input wire        txc_tlast,
  input wire        txc_tready,
  input wire        txd_tvalid,
  input wire        txd_tlast,
  input wire        txd_tready,
  input wire        mtx_tvalid,
  input wire [31:0] mtx_tdata,
  input wire        mtx_tlast,
  input wire [15:0] mtx_tcsum,
  input wire        mtx_tready,
  // Receive streams
  input wire        mrx_tvalid,
  input wire        mrx_tlast,
  input wire        mrx_bad,
  input wire        rxd_tvalid,
  input wire [31:0] rxd_tdata,
  input wire        rxd_tlast,
  input wire [15:0] rxd_tcsum,
  input wire        rxd_tready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_ctl_end; txc_tvalid && txc_tready && txc_tlast |=> !txc_tready;
  endproperty
  a_ctl_end: assert property (p_ctl_end) else $error("ctl ready held");
  property p_excl; txd_tready |-> !txc_tready; endproperty
  a_excl: assert property (p_excl) else $error("both ready");
  property p_data_end;
    txd_tvalid && txd_tready && txd_tlast |=> txc_tready && !txd_tready;
  endproperty
  a_data_end: assert property (p_data_end) else $error("no ctl ready");
  property p_mtx_hold;
    mtx_tvalid && !mtx_tready |=> mtx_tvalid && $stable(mtx_tdata)
      && $stable(mtx_tlast);
  endproperty
  a_mtx_hold: assert property (p_mtx_hold) else $error("mtx moved");
  property p_mtx_csum; mtx_tvalid && !mtx_tlast |-> mtx_tcsum == 16'h0;
  endproperty
  a_mtx_csum: assert property (p_mtx_csum) else $error("tx csum");
  property p_rxd_csum; rxd_tvalid && !rxd_tlast |-> rxd_tcsum == 16'h0;
  endproperty
  a_rxd_csum: assert property (p_rxd_csum) else $error("rx csum");
  property p_bad_drop;
    mrx_tvalid && mrx_tlast && mrx_bad && !rxd_tvalid |=> !rxd_tvalid [*3];
  endproperty
  a_bad_drop: assert property (p_bad_drop) else $error("bad fwd");
  property p_rxd_hold;
    rxd_tvalid && !rxd_tready |=> rxd_tvalid && $stable(rxd_tdata)
      && $stable(rxd_tlast);
  endproperty
  a_rxd_hold: assert property (p_rxd_hold) else $error("rxd moved");
  // Zero wait states
  property p_apb_rdy; psel && penable |-> pready; endproperty
  a_apb_rdy: assert property (p_apb_rdy) else $error("no pready");
  // Unmapped access above 8'h4C refused
  property p_apb_err; psel && penable && paddr > 8'h4C |-> pslverr;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("no pslverr");
  c_tx: cover property (txd_tvalid && txd_tready && txd_tlast);
  c_stall: cover property (rxd_tvalid && !rxd_tready);
  c_bad: cover property (mrx_tvalid && mrx_tlast && mrx_bad);
endmodule // efb_top_chk

//--- test/efb_sys_model.sv
// System-side partner: transmit stream source, receive stream sink
`timescale 1ns/100ps
module efb_sys_model (
  // Clock
  input  wire         clk,
  // Transmit control stream
  output logic        txc_tvalid,
  output logic [31:0] txc_tdata,
  output logic        txc_tlast,
  input  wire         txc_tready,
  // Transmit data stream
  output logic        txd_tvalid,
  output logic [31:0] txd_tdata,
  output logic [3:0]  txd_tkeep,
  output logic        txd_tlast,
  input  wire         txd_tready,
  // Receive stream
  input  wire         rxd_tvalid,
  input  wire [31:0]  rxd_tdata,
  output logic        rxd_tready
);
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] rx_q[$];

  initial begin
    {txc_tvalid, txc_tlast, txd_tvalid, txd_tlast, rxd_tready} = 5'h00;
    {txc_tdata, txd_tdata} = 64'h0;
    txd_tkeep = 4'hF;
  end

  // Slow mode drops ready every other cycle to stress the hold
  always @(posedge clk) begin
    rxd_tready <= !stall && !(slow && rxd_tready);
    if (rxd_tvalid && rxd_tready)
      rx_q.push_back(rxd_tdata);
  end

  task automatic send_tx(input int n, input logic [31:0] base);
    for (int i = 0; i < 6; i++) begin
      txc_tvalid <= 1'b1;
      txc_tdata  <= 32'hA0000000 | 32'(i);
      txc_tlast  <= (i == 5);
      do @(posedge clk); while (!txc_tready);
    end
    txc_tvalid <= 1'b0;
    txc_tdata  <= ~txc_tdata;
    for (int i = 0; i < n; i++) begin
      txd_tvalid <= 1'b1;
      txd_tdata  <= base + 32'(i);
      txd_tkeep  <= (i == n - 1) ? 4'h3 : 4'hF;
      txd_tlast  <= (i == n - 1);
      do @(posedge clk); while (!txd_tready);
    end
    txd_tvalid <= 1'b0;
    txd_tdata  <= ~txd_tdata;
  endtask
endmodule // efb_sys_model

//--- test/tb_top.sv
// Self-checking bench for the frame buffering block
`timescale 1ns/100ps
`include "efb_defs.vh"
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        mtx_tready = 1'b1;
  logic        mrx_tvalid = 1'b0;
  logic [31:0] mrx_tdata = 32'h0;
  logic [3:0]  mrx_tkeep = 4'hF;
  logic        mrx_tlast = 1'b0;
  logic        mrx_bad = 1'b0;
  wire  [31:0] prdata, txc_tdata, txd_tdata, mtx_tdata, rxd_tdata;
  wire  [15:0] mtx_tcsum, rxd_tcsum;
  wire  [3:0]  txd_tkeep, mtx_tkeep, rxd_tkeep;
  wire         pready, pslverr, irq, txc_tvalid, txc_tlast, txc_tready;
  wire         txd_tvalid, txd_tlast, txd_tready, mtx_tvalid, mtx_tlast;
  wire         rxd_tvalid, rxd_tlast, rxd_tready;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          tx_frames = 0;
  int          rx_frames = 0;
  logic [31:0] tx_q[$];
  logic [31:0] exp_rx[$];
  logic [3:0]  tx_keep;
  logic [15:0] tx_csum;
  logic [15:0] rx_tag = 16'h0100;
  logic [31:0] q;
  logic        err;

  efb_top #(.tx_checksum_option(1), .rx_checksum_option(1)) dut (.*);
  efb_sys_model u_sys (.*);

  initial forever #5 clk = ~clk;

  // MAC-side sink records every transmit beat
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rxd_tvalid && rxd_tready && rxd_tlast && rxd_tkeep == 4'hF)
      rx_frames <= rx_frames + 1;
    if (mtx_tvalid && mtx_tready) begin
      tx_q.push_back(mtx_tdata);
      if (mtx_tlast) begin
        tx_frames <= tx_frames + 1;
        tx_keep   <= mtx_tkeep;
        tx_csum   <= mtx_tcsum;
      end
    end
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Ones-complement sum of all 16-bit halves, end-around carry
  function automatic logic [15:0] csum(input logic [31:0] b, input int n);
    logic [16:0] s;
    logic [31:0] w;
    s = 17'h0;
    for (int i = 0; i < n; i++) begin
      w = b + 32'(i);
      s = s[15:0] + s[16] + w[15:0];
      s = s[15:0] + s[16] + w[31:16];
    end
    return s[15:0] + s[16];
  endfunction

  task automatic mac_frame(input logic [47:0] da, input int n,
                           input logic bad, input logic good);
    logic [31:0] w;
    for (int i = 0; i < n; i++) begin
      w = (i == 0) ? da[31:0] : {rx_tag, 16'(i)};
      if (i == 1)
        w = {16'hBEEF, da[47:32]};
      mrx_tvalid <= 1'b1;
      mrx_tdata  <= w;
      mrx_tlast  <= (i == n - 1);
      mrx_bad    <= bad && (i == n - 1);
      if (good)
        exp_rx.push_back(w);
      @(posedge clk);
    end
    mrx_tvalid <= 1'b0;
    mrx_tdata  <= ~w;
    rx_tag     <= rx_tag + 16'h1;
    @(posedge clk);
  endtask

  // Receive output can pause between frames, so wait for a quiet spell
  task automatic drain();
    int idle;
    idle = 0;
    for (int i = 0; i < 4000 && idle < 8; i++) begin
      @(posedge clk);
      idle = rxd_tvalid ? 0 : idle + 1;
    end
  endtask

  task automatic cmp_rx();
    for (int i = 0; i < u_sys.rx_q.size(); i++)
      check(u_sys.rx_q[i], exp_rx[i], "rx data");
    u_sys.rx_q.delete();
    exp_rx.delete();
  endtask

  task automatic s_regs();
    apb(1'b0, `EFB_REG_CTRL, 32'h0);
    check(q, {28'h0, `EFB_CTRL_RESET}, "ctrl reset");
    apb(1'b0, 8'h50, 32'h0);
    check({q[31:1], err}, 32'h1, "unmapped");
    apb(1'b1, `EFB_REG_UNI_LO, 32'h33221102);
    apb(1'b1, `EFB_REG_UNI_HI, 32'h00005544);
  endtask

  task automatic s_tx();
    check({31'h0, txd_tready}, 32'h0, "data ready early");
    u_sys.send_tx(20, 32'h12340000);
    for (int i = 0; i < 300 && tx_frames < 1; i++) @(posedge clk);
    check(32'(tx_q.size()), 32'h14, "tx words");
    for (int i = 0; i < 20; i++) check(tx_q[i], 32'h12340000 + i, "tx");
    check({28'h0, tx_keep}, 32'h3, "tx keep");
    check({16'h0, tx_csum}, {16'h0, csum(32'h12340000, 20)}, "csum");
    tx_q.delete();
    check({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, `EFB_REG_IRQ_MASK, 32'h1);
    @(negedge clk);
    check({31'h0, irq}, 32'h1, "irq on");
    apb(1'b1, `EFB_REG_IRQ_STAT, 32'h1);
    @(negedge clk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    apb(1'b1, `EFB_REG_IRQ_MASK, 32'h0);
  endtask

  task automatic s_rx();
    logic [47:0] mc;
    mac_frame(48'h554433221102, 16, 1'b0, 1'b1);
    mac_frame(48'h554433221104, 16, 1'b0, 1'b0);
    mac_frame(48'h554433221102, 16, 1'b1, 1'b0);
    mac_frame(48'h554433221102, 15, 1'b0, 1'b0);
    mac_frame(48'hFFFFFFFFFFFF, 17, 1'b0, 1'b1);
    mac_frame(48'h00C0FFEE0901, 16, 1'b0, 1'b0);
    for (int k = 0; k < `EFB_MC_COUNT; k++) begin
      mc = {32'h00C0FFEE, 8'(k), 8'h01};
      apb(1'b1, 8'(`EFB_REG_MC_BASE + 8 * k), mc[31:0]);
      apb(1'b1, 8'(`EFB_REG_MC_BASE + 4 + 8 * k), {16'h0, mc[47:32]});
      mac_frame(mc, 16, 1'b0, 1'b1);
    end
    drain();
    check(32'(u_sys.rx_q.size()), 32'(exp_rx.size()), "rx words");
    check(32'(rx_frames), 32'h6, "rx frames");
    cmp_rx();
    apb(1'b0, `EFB_REG_IRQ_STAT, 32'h0);
    check(q, 32'h0000001A, "drop causes");
  endtask

  task automatic s_rx_full();
    u_sys.stall <= 1'b1;
    // One odd-sized frame leaves the memory exactly full after commits
    for (int f = 0; f < 70; f++)
      mac_frame(48'h554433221102, (f == 0) ? 17 : 16, 1'b0, 1'b1);
    apb(1'b0, `EFB_REG_LEVEL, 32'h0);
    check(q & 32'h10, 32'h10, "rx full");
    apb(1'b0, `EFB_REG_IRQ_STAT, 32'h0);
    check(q & 32'h4, 32'h4, "drop on full");
    u_sys.stall <= 1'b0;
    u_sys.slow  <= 1'b1;
    drain();
    check(32'(u_sys.rx_q.size() % 16), 32'h1, "whole frames");
    check(32'(u_sys.rx_q.size() inside {[16:1104]}), 32'h1, "kept");
    cmp_rx();
    mac_frame(48'h554433221102, 16, 1'b0, 1'b1);
    drain();
    check(32'(u_sys.rx_q.size()), 32'h10, "accepts again");
    cmp_rx();
  endtask

  task automatic s_tx_full();
    mtx_tready <= 1'b0;
    fork
      for (int f = 0; f < 17; f++) u_sys.send_tx(64, 32'(f) << 20);
    join_none
    for (int i = 0; i < 1000 && !q[5]; i++) apb(1'b0, `EFB_REG_LEVEL, 32'h0);
    check({31'h0, q[5]}, 32'h1, "tx full");
    @(negedge clk);
    check({30'h0, txd_tvalid, txd_tready}, 32'h2, "tx stalled");
    @(posedge clk);
    mtx_tready <= 1'b1;
    wait fork;
    for (int i = 0; i < 3000 && tx_frames < 18; i++) @(posedge clk);
    check(32'(tx_q.size()), 32'h440, "tx words after stall");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_tx();
    s_rx();
    s_rx_full();
    s_tx_full();
    stop_test();
  end
endmodule // tb_top

bind efb_top efb_top_chk u_chk (.*);
